// ### design/rps_port_status.v
// Root hub port status and control register with its change flags.
// Assumes an APB master, and port line events already synchronous to CLK.
//
// How it works
// - Unused bits 31:21, 15:10 and 7:5 ignore writes and read zero.
// - Finished port reset sets bit 20; writing one clears it.
// - Any over-current indicator change sets bit 19; writing one clears it.
// - Finished resume sets bit 18; one-write or bit 20 setting clears it.
// - Over-current, disconnect power-off or bubble error sets bit 17; one-write clears.
// - Connect change, removable mask set, or commands without device set bit 16.
// - Bit 9 reads one for a low-speed device, zero for full speed.
// - Low-speed connect sets speed indication; full-speed connect clears it.
// - Bit 8 reads one while the port is powered.
// - Ganged mode: global power-on command powers the port.
// - Per-port mode, mask zero: global power-on command powers the port.
// - Per-port mode, mask one: own power-on write powers the port.
// - Ganged mode with switching: global power-off command removes power.
// - Per-port mode, mask zero: global power-off command removes power.
// - Per-port mode, mask one: own power-off write removes power.
// - Over-current always removes port power.
// - Reset command starts a port reset only with a device connected.
// - Reset ends on completion flag in running state, or on power loss.
// - Bit 0 reads one while a device is connected.
// - Bit 4 reads one while port reset is driven.
// - Port state and change flags are initialised only by hardware reset.
`timescale 1ns/10ps
`default_nettype none
`include "rps_map.vh"

module rps_port_status
#(
    parameter ADDR_W = 8
)
(
    // Clock and reset
    input  wire              CLK,
    input  wire              RESET_N,
    // APB slave
    input  wire              PSEL,
    input  wire              PENABLE,
    input  wire              PWRITE,
    input  wire [ADDR_W-1:0] PADDR,
    input  wire [31:0]       PWDATA,
    output reg  [31:0]       PRDATA,
    output wire              PREADY,
    output wire              PSLVERR,
    // Port line events
    input  wire              CONNECT_DET,
    input  wire              LOW_SPEED_DET,
    input  wire              OVERCURRENT_DET,
    input  wire              RESET_DONE,
    input  wire              RESUME_DONE,
    input  wire              BUBBLE_ERROR,
    input  wire              DISCONNECT_POWER_OFF,
    // Port controls
    output wire              PORT_POWER,
    output wire              PORT_RESET,
    output wire              PORT_ENABLE,
    output wire              PORT_SUSPEND
);

    // Bus decode
    wire        setup_rd;
    wire        wr;
    wire        hit_config;
    wire        hit_global;
    wire        hit_port;
    wire        mapped;
    wire        wr_port;
    wire        wr_global;
    wire        wr_config;

    // Configuration
    reg  [5:0]  config_reg;
    wire        power_switch_per_port;
    wire        no_power_switching;
    wire        port_power_mask;
    wire        removable_device_mask;
    wire [1:0]  controller_functional_state;

    // Port state
    reg         connected;
    reg         connect_prev;
    reg         port_overcurrent_flag;
    reg         oc_prev;
    reg         port_powered;
    reg         port_reset_active;
    reg         port_enabled;
    reg         port_suspended;
    reg         slow_device_attached;
    reg         reset_done_change;
    reg         overcurrent_change;
    reg         suspend_change;
    reg         enable_change;
    reg         connect_change;

    // Commands and events
    wire        global_power_on_cmd;
    wire        global_power_off_cmd;
    wire        port_power_on_cmd;
    wire        port_power_off_cmd;
    wire        port_reset_cmd;
    wire        port_enable_cmd;
    wire        port_suspend_cmd;
    wire        port_disable_cmd;
    wire        power_on;
    wire        power_off;
    wire        set_reset_chg;
    wire        set_oc_chg;
    wire        set_susp_chg;
    wire        set_en_chg;
    wire        set_conn_chg;
    wire        connect_rise;
    wire        removable_rise;
    wire        oc_rise;
    wire [31:0] port_word;

    // Write-one strobe of a bit in a written register word
    function one_written;
        input [31:0] data;
        input integer pos;
        begin
            one_written = data[pos];
        end
    endfunction

    assign setup_rd   = PSEL & ~PENABLE & ~PWRITE;
    assign wr         = PSEL & PENABLE & PWRITE;
    assign hit_config = (PADDR == `RPS_OFF_CONFIG);
    assign hit_global = (PADDR == `RPS_OFF_GLOBAL);
    assign hit_port   = (PADDR == `RPS_OFF_PORT);
    assign mapped     = hit_config | hit_global | hit_port;
    assign wr_port    = wr & hit_port;
    assign wr_global  = wr & hit_global;
    assign wr_config  = wr & hit_config;

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    assign power_switch_per_port       = config_reg[`RPS_BIT_PER_PORT];
    assign no_power_switching          = config_reg[`RPS_BIT_NO_SWITCH];
    assign port_power_mask             = config_reg[`RPS_BIT_POWER_MASK];
    assign removable_device_mask       = config_reg[`RPS_BIT_REMOVABLE];
    assign controller_functional_state = config_reg[`RPS_FS_HI:`RPS_FS_LO];

    // Only ones act; zeros in a port or global write leave everything alone
    assign global_power_on_cmd  = wr_global & one_written(PWDATA, `RPS_BIT_GLOBAL_ON);
    assign global_power_off_cmd = wr_global & one_written(PWDATA, `RPS_BIT_GLOBAL_OFF);
    assign port_power_on_cmd    = wr_port & one_written(PWDATA, `RPS_BIT_POWER);
    assign port_power_off_cmd   = wr_port & one_written(PWDATA, `RPS_BIT_SLOW);
    assign port_reset_cmd       = wr_port & one_written(PWDATA, `RPS_BIT_RESET);
    assign port_enable_cmd      = wr_port & one_written(PWDATA, `RPS_BIT_ENABLE);
    assign port_suspend_cmd     = wr_port & one_written(PWDATA, `RPS_BIT_SUSPEND);
    assign port_disable_cmd     = wr_port & one_written(PWDATA, `RPS_BIT_CONNECT);

    assign power_on = (global_power_on_cmd & ~power_switch_per_port)
        | (global_power_on_cmd & ~no_power_switching & power_switch_per_port
           & ~port_power_mask)
        | (port_power_on_cmd & ~no_power_switching & power_switch_per_port
           & port_power_mask);

    assign power_off = (global_power_off_cmd & ~no_power_switching
           & ~power_switch_per_port)
        | (global_power_off_cmd & ~no_power_switching & power_switch_per_port
           & ~port_power_mask)
        | (port_power_off_cmd & ~no_power_switching & power_switch_per_port
           & port_power_mask)
        | OVERCURRENT_DET;

    assign connect_rise   = CONNECT_DET & ~connect_prev;
    assign oc_rise        = OVERCURRENT_DET & ~oc_prev;
    assign removable_rise = wr_config & one_written(PWDATA, `RPS_BIT_REMOVABLE)
                            & ~removable_device_mask;

    // A completion that arrives outside a reset is not a reset completion
    assign set_reset_chg = RESET_DONE & port_reset_active;
    assign set_oc_chg    = OVERCURRENT_DET ^ oc_prev;
    assign set_susp_chg  = RESUME_DONE;
    assign set_en_chg    = oc_rise | DISCONNECT_POWER_OFF | BUBBLE_ERROR;
    assign set_conn_chg  = (CONNECT_DET ^ connect_prev) | removable_rise
        | (~connected & (port_reset_cmd | port_enable_cmd | port_suspend_cmd));

    // Configuration and sampled line levels
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            config_reg            <= `RPS_CONFIG_RESET;
            connected             <= 1'b0;
            connect_prev          <= 1'b0;
            port_overcurrent_flag <= 1'b0;
            oc_prev               <= 1'b0;
        end
        else
        begin
            if (wr_config)
                config_reg <= PWDATA[5:0];
            connected             <= CONNECT_DET;
            connect_prev          <= CONNECT_DET;
            port_overcurrent_flag <= OVERCURRENT_DET;
            oc_prev               <= OVERCURRENT_DET;
        end
    end

    // Port state; only the hardware reset initialises it
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            port_powered         <= `RPS_FLAG_RESET;
            port_reset_active    <= `RPS_FLAG_RESET;
            port_enabled         <= `RPS_FLAG_RESET;
            port_suspended       <= `RPS_FLAG_RESET;
            slow_device_attached <= `RPS_FLAG_RESET;
        end
        else
        begin
            // Power-off wins so an over-current can never be overridden
            if (power_off)
                port_powered <= 1'b0;
            else if (power_on)
                port_powered <= 1'b1;

            if ((set_reset_chg & (controller_functional_state == `RPS_FS_RUNNING))
                | ~port_powered)
                port_reset_active <= 1'b0;
            else if (port_reset_cmd & connected)
                port_reset_active <= 1'b1;

            if (set_en_chg | port_disable_cmd | ~port_powered)
                port_enabled <= 1'b0;
            else if ((port_enable_cmd & connected) | set_reset_chg | set_susp_chg)
                port_enabled <= 1'b1;

            if (set_susp_chg | set_reset_chg | ~port_powered)
                port_suspended <= 1'b0;
            else if (port_suspend_cmd & connected)
                port_suspended <= 1'b1;

            if (connect_rise)
                slow_device_attached <= LOW_SPEED_DET;
        end
    end

    // Change flags: a set in the same cycle as a clear wins
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            reset_done_change  <= `RPS_FLAG_RESET;
            overcurrent_change <= `RPS_FLAG_RESET;
            suspend_change     <= `RPS_FLAG_RESET;
            enable_change      <= `RPS_FLAG_RESET;
            connect_change     <= `RPS_FLAG_RESET;
        end
        else
        begin
            reset_done_change  <= set_reset_chg | (reset_done_change
                & ~(wr_port & PWDATA[`RPS_BIT_RESET_CHG]));
            overcurrent_change <= set_oc_chg | (overcurrent_change
                & ~(wr_port & PWDATA[`RPS_BIT_OC_CHG]));
            suspend_change     <= set_susp_chg | (suspend_change
                & ~(wr_port & PWDATA[`RPS_BIT_SUSPEND_CHG]) & ~set_reset_chg);
            enable_change      <= set_en_chg | (enable_change
                & ~(wr_port & PWDATA[`RPS_BIT_ENABLE_CHG]));
            connect_change     <= set_conn_chg | (connect_change
                & ~(wr_port & PWDATA[`RPS_BIT_CONNECT_CHG]));
        end
    end

    // Reserved positions are tied to zero
    assign port_word = {11'h000,
                        reset_done_change,
                        overcurrent_change,
                        suspend_change,
                        enable_change,
                        connect_change,
                        6'h00,
                        slow_device_attached,
                        port_powered,
                        3'h0,
                        port_reset_active,
                        port_overcurrent_flag,
                        port_suspended,
                        port_enabled,
                        connected};

    // Read data is captured in the setup cycle so the access needs no wait
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            PRDATA <= 32'h00000000;
        else if (setup_rd)
        begin
            if (hit_port)
                PRDATA <= port_word;
            else if (hit_config)
                PRDATA <= {26'h0000000, config_reg};
            else
                PRDATA <= 32'h00000000;
        end
    end

    assign PORT_POWER   = port_powered;
    assign PORT_RESET   = port_reset_active;
    assign PORT_ENABLE  = port_enabled;
    assign PORT_SUSPEND = port_suspended;

endmodule // rps_port_status

`default_nettype wire

// ### include/rps_map.vh
// Register map, field positions and reset values of the root port status block.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

// Register byte offsets
`define RPS_OFF_CONFIG        8'h48
`define RPS_OFF_GLOBAL        8'h50
`define RPS_OFF_PORT          8'h54

// Port register fields
`define RPS_BIT_CONNECT       0
`define RPS_BIT_ENABLE        1
`define RPS_BIT_SUSPEND       2
`define RPS_BIT_OVERCURRENT   3
`define RPS_BIT_RESET         4
`define RPS_BIT_POWER         8
`define RPS_BIT_SLOW          9
`define RPS_BIT_CONNECT_CHG   16
`define RPS_BIT_ENABLE_CHG    17
`define RPS_BIT_SUSPEND_CHG   18
`define RPS_BIT_OC_CHG        19
`define RPS_BIT_RESET_CHG     20

// Global command fields (write only, read as zero)
`define RPS_BIT_GLOBAL_OFF    0
`define RPS_BIT_GLOBAL_ON     16

// Configuration fields
`define RPS_BIT_PER_PORT      0
`define RPS_BIT_NO_SWITCH     1
`define RPS_BIT_POWER_MASK    2
`define RPS_BIT_REMOVABLE     3
`define RPS_FS_LO             4
`define RPS_FS_HI             5

// Reset values
`define RPS_CONFIG_RESET      6'h00
`define RPS_FLAG_RESET        1'b0

// Functional state in which a finished reset ends the reset state
`define RPS_FS_RUNNING        2'h1

`endif

// ### test/rps_dev_model.sv
// Downstream device model: attach, speed, over-current and reset completion.
// Assumes bench control levels that change just after CLK edges.
`timescale 1ns/10ps
`default_nettype none
module rps_dev_model #(parameter RST_CYC = 10) (
    // Bench controls
    input wire logic CLK, RESET_N, attach, slow, fault,
    // Port side
    input wire logic PORT_RESET,
    output logic     CONNECT_DET, LOW_SPEED_DET, OVERCURRENT_DET, RESET_DONE
);
    logic [7:0] cnt;
    always @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
        begin
            {CONNECT_DET, LOW_SPEED_DET, OVERCURRENT_DET, RESET_DONE} <= 4'h0;
            cnt <= 8'h00;
        end
        else
        begin
            CONNECT_DET     <= attach;
            // Detached speed line floats, so it toggles instead of holding
            LOW_SPEED_DET   <= attach ? slow : ~LOW_SPEED_DET;
            OVERCURRENT_DET <= fault;
            cnt             <= PORT_RESET ? cnt + 8'h01 : 8'h00;
            RESET_DONE      <= PORT_RESET && cnt == RST_CYC - 1;
        end
endmodule // rps_dev_model
`default_nettype wire

// ### test/rps_port_status_props.sv
// Checker for the root port status block, bound to its top module.
// Assumes APB with zero wait states and port events synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
`include "rps_map.vh"
module rps_port_status_props #(parameter ADDR_W = 8) (
    // Clock, reset and APB
    input wire logic              CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA, PRDATA,
    // Port lines
    input wire logic              CONNECT_DET, OVERCURRENT_DET, RESET_DONE, PORT_POWER, PORT_RESET
);
    // Connect read lags two edges, so hold it off until history is valid
    logic [1:0] up;
    always @(posedge CLK or negedge RESET_N)
        if (!RESET_N) up <= 2'b00;
        else up <= {up[0], 1'b1};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence rd_port;
        PSEL && PENABLE && !PWRITE && PADDR == `RPS_OFF_PORT;
    endsequence
    sequence rst_cmd;
        PSEL && PENABLE && PWRITE && PADDR == `RPS_OFF_PORT && PWDATA[4];
    endsequence
    sequence reset_held;
        PORT_RESET && !RESET_DONE && PORT_POWER;
    endsequence
    chk_reserved_zero: assert property (
        rd_port |-> (PRDATA & 32'hffe0fce0) == 32'h0) else $error("reserved bits read nonzero");
    chk_power_read: assert property (
        rd_port |-> PRDATA[8] == $past(PORT_POWER)) else $error("power bit wrong");
    chk_reset_read: assert property (
        rd_port |-> PRDATA[4] == $past(PORT_RESET)) else $error("reset bit wrong");
    chk_connect_read: assert property (
        up[1] ##0 rd_port |-> PRDATA[0] == $past(CONNECT_DET, 2)) else $error("connect bit wrong");
    chk_oc_power: assert property (
        OVERCURRENT_DET |=> !PORT_POWER) else $error("power kept in over-current");
    chk_reset_start: assert property (
        (!PORT_RESET && !CONNECT_DET && !$past(CONNECT_DET)) ##0 rst_cmd |=> !PORT_RESET)
        else $error("reset started with no device");
    chk_reset_off: assert property (
        $fell(PORT_POWER) |-> ##[0:1] !PORT_RESET) else $error("reset kept after power off");
    chk_reset_hold: assert property (
        reset_held ##1 PORT_POWER |-> PORT_RESET) else $error("reset ended early");
endmodule // rps_port_status_props
bind rps_port_status rps_port_status_props #(.ADDR_W(ADDR_W)) u_props (.CLK(CLK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .CONNECT_DET(CONNECT_DET),
    .OVERCURRENT_DET(OVERCURRENT_DET), .RESET_DONE(RESET_DONE), .PORT_POWER(PORT_POWER),
    .PORT_RESET(PORT_RESET));
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the root port status block.
// Assumes zero-wait APB; reads are checked from a queue of expectations.
`timescale 1ns/10ps
`default_nettype none
`include "rps_map.vh"
module tb_top;
    localparam logic [7:0] P = `RPS_OFF_PORT, G = `RPS_OFF_GLOBAL, C = `RPS_OFF_CONFIG;
    logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, attach, slow, fault;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic        PREADY, PSLVERR, CONNECT_DET, LOW_SPEED_DET, OVERCURRENT_DET, RESET_DONE;
    logic        PORT_POWER, PORT_RESET, PORT_ENABLE, PORT_SUSPEND;
    logic [2:0]  ev;
    logic [32:0] eq[$], mq[$];
    int          err_count, num_checks, k;
    logic [5:0]  tc[8] = '{6'h00, 6'h00, 6'h01, 6'h01, 6'h05, 6'h05, 6'h05, 6'h05};
    logic [7:0]  ta[8] = '{G, G, G, G, G, P, G, P};
    logic [31:0] td[8] = '{32'h10000, 32'h1, 32'h10000, 32'h1, 32'h10000, 32'h100, 32'h1, 32'h200};
    logic        tp[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    rps_port_status u_dut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CONNECT_DET(CONNECT_DET), .LOW_SPEED_DET(LOW_SPEED_DET),
        .OVERCURRENT_DET(OVERCURRENT_DET), .RESET_DONE(RESET_DONE), .RESUME_DONE(ev[0]),
        .BUBBLE_ERROR(ev[1]), .DISCONNECT_POWER_OFF(ev[2]), .PORT_POWER(PORT_POWER),
        .PORT_RESET(PORT_RESET), .PORT_ENABLE(PORT_ENABLE), .PORT_SUSPEND(PORT_SUSPEND));
    rps_dev_model #(.RST_CYC(10)) u_dev (.CLK(CLK), .RESET_N(RESET_N), .attach(attach),
        .slow(slow), .fault(fault), .PORT_RESET(PORT_RESET), .CONNECT_DET(CONNECT_DET),
        .LOW_SPEED_DET(LOW_SPEED_DET), .OVERCURRENT_DET(OVERCURRENT_DET), .RESET_DONE(RESET_DONE));
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin err_count++; stop_test(); end
        PSEL <= 1'b0; PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
        mq.push_back(m); eq.push_back(e); apb(a, 1'b0, 32'h0);
    endtask
    task automatic pulse(input int b);
        @(posedge CLK); ev[b] <= 1'b1;
        @(posedge CLK); ev[b] <= 1'b0;
    endtask
    // Watcher takes the oldest expectation whenever a read completes
    always @(posedge CLK)
        if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1 && mq.size() > 0)
        begin
            chk("read data", {PSLVERR, PRDATA} & mq[0], eq[0]);
            void'(mq.pop_front()); void'(eq.pop_front());
        end
    initial
    begin
        {RESET_N, PSEL, PENABLE, PWRITE, attach, slow, fault, ev} = 10'h0;
        PADDR = 8'h00; PWDATA = 32'h0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        void'($urandom(32'h14d8));
        rd(P, 33'h1ffffffff, 33'h0);
        rd(C, 33'h1ffffffff, 33'h0);
        rd(8'h00, 33'h1ffffffff, 33'h100000000);
        for (k = 0; k < 8; k++)
        begin
            wr(C, {26'h0, tc[k]}); wr(ta[k], td[k]);
            rd(P, 33'h100, {24'h0, tp[k], 8'h0});
        end
        wr(P, $urandom & 32'hffe0fce0);
        wr(C, 32'h10); wr(G, 32'h10000);
        attach <= 1'b1; slow <= 1'b1; repeat (3) @(posedge CLK);
        rd(P, 33'h1fffffff1, 33'h10301);
        wr(P, 32'h10000); rd(P, 33'h1fffffff1, 33'h301);
        wr(P, 32'h4); @(negedge CLK); chk("suspend on", PORT_SUSPEND, 33'h1);
        wr(P, 32'h10); @(negedge CLK); chk("reset on", PORT_RESET, 33'h1);
        // Resume must also drop the suspend state set just above
        pulse(0); rd(P, 33'h40014, 33'h40010);
        k = 0;
        while (PORT_RESET !== 1'b0 && k < 50) begin @(posedge CLK); k++; end
        if (k >= 50) begin err_count++; stop_test(); end
        rd(P, 33'h150010, 33'h100000);
        wr(P, 32'h100000); rd(P, 33'h100000, 33'h0);
        fault <= 1'b1; repeat (3) @(posedge CLK);
        chk("power in fault", PORT_POWER, 33'h0);
        chk("enable in fault", PORT_ENABLE, 33'h0);
        rd(P, 33'ha0100, 33'ha0000);
        wr(P, 32'ha0000); fault <= 1'b0; repeat (3) @(posedge CLK);
        rd(P, 33'ha0000, 33'h80000);
        for (k = 1; k < 3; k++)
        begin
            wr(P, 32'ha0000); pulse(k); rd(P, 33'h20000, 33'h20000);
        end
        attach <= 1'b0; repeat (3) @(posedge CLK);
        // Power the port again so only the missing device can refuse the reset
        wr(G, 32'h10000); wr(P, 32'h30000); wr(P, 32'h10); @(negedge CLK);
        chk("reset refused", PORT_RESET, 33'h0);
        rd(P, 33'h10011, 33'h10000);
        wr(P, 32'h10000); slow <= 1'b0; attach <= 1'b1; repeat (3) @(posedge CLK);
        rd(P, 33'h201, 33'h1);
        wr(P, 32'h10000); wr(C, 32'h18); rd(P, 33'h10000, 33'h10000);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
